//--- logic/host_decode_pkg.sv
`default_nettype none
package host_decode_pkg;

	// Gate-array register offsets above the jumper-chosen I/O base.
	localparam logic [15:0] OFS_PAGE_FIRST  = 16'h0400;
	localparam logic [15:0] OFS_PAGE_LAST   = 16'h0401;
	localparam logic [15:0] OFS_BURST_LEN   = 16'h0402;
	localparam logic [15:0] OFS_IO_BASE     = 16'h0403;
	localparam logic [15:0] OFS_ROM_BASE    = 16'h0404;
	localparam logic [15:0] OFS_ARRAY_CFG   = 16'h0405;
	localparam logic [15:0] OFS_CTRL        = 16'h0406;
	localparam logic [15:0] OFS_STATUS      = 16'h0407;
	localparam logic [15:0] OFS_IRQ_DMA     = 16'h0408;
	localparam logic [15:0] OFS_DMA_HIGH    = 16'h0409;
	localparam logic [15:0] OFS_DMA_LOW     = 16'h040a;
	localparam logic [15:0] OFS_VECTOR_2    = 16'h040b;
	localparam logic [15:0] OFS_VECTOR_1    = 16'h040c;
	localparam logic [15:0] OFS_VECTOR_0    = 16'h040d;
	localparam logic [15:0] OFS_PORT_LOW    = 16'h040e;
	localparam logic [15:0] OFS_PORT_HIGH   = 16'h040f;

	// Values after reset.
	localparam logic [7:0] RESET_ZERO       = 8'h00;
	localparam logic [7:0] RESET_CTRL       = 8'h0a;
	localparam logic [7:0] CTRL_IN_SRST     = 8'h0b;

	// Field positions.
	localparam int CTRL_SRST_BIT            = 0;
	localparam int CTRL_WIN_LO_BIT          = 2;
	localparam int CTRL_WIN_HI_BIT          = 3;
	localparam int CFG_RAM_MAP_BIT          = 3;
	localparam int CFG_BANK_HI              = 2;
	localparam int ROM_OPT_LO               = 4;
	localparam int ROM_TAIL_LO              = 1;
	localparam int MEM_WIN_LO               = 13;

	// Option bit n of the I/O base register selects IO_BASE_TABLE[n].
	localparam logic [7:0][15:0] IO_BASE_TABLE = {
		16'h0300, 16'h0310, 16'h0330, 16'h0350,
		16'h0250, 16'h0280, 16'h02a0, 16'h02e0};

	// Option bit 4+n of the boot PROM register selects ROM_BASE_TABLE[n].
	localparam logic [3:0][19:0] ROM_BASE_TABLE = {
		20'hd_c000, 20'hd_8000, 20'hc_c000, 20'hc_8000};

	// Synchroniser depth for the jumper pins.
	localparam int SYNC_STAGES              = 3;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} io_req_type;

	typedef struct packed {
		logic [19:0] addr;
		logic        rd;
		logic        wr;
	} mem_req_type;

	typedef struct packed {
		logic [7:0] page_first;
		logic [7:0] page_last;
		logic [7:0] burst_len;
		logic [7:0] io_base;
		logic [7:0] rom_base;
		logic [7:0] array_cfg;
		logic [7:0] ctrl;
		logic [7:0] irq_dma;
		logic [7:0] dma_high;
		logic [7:0] dma_low;
		logic [7:0] vector_2;
		logic [7:0] vector_1;
		logic [7:0] vector_0;
	} regs_type;

	typedef struct packed {
		logic       lan_sel;
		logic       prom_sel;
		logic [4:0] prom_byte;
		logic [3:0] lan_reg;
		logic       rom_sel;
		logic       ram_sel;
		logic [15:0] local_addr;
	} decode_type;

endpackage
`default_nettype wire

//--- logic/data_port_file.sv
`timescale 1ns/100ps
`default_nettype none
module data_port_file #(
	parameter int DEPTH = 16
) (
	input  wire logic       core_clk,
	input  wire logic       clear_ptr,
	input  wire logic       port_rd,
	input  wire logic       port_wr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata
);
	import host_decode_pkg::*;

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [PW-1:0]         ptr;
	} state_type;

	state_type q;
	state_type d;

	// Storage is never cleared, so residual data survives a reset.
	always_comb begin
		d = q;
		if (clear_ptr) begin
			d.ptr = '0;
		end else if (port_wr) begin
			d.mem[q.ptr] = wdata;
			d.ptr = q.ptr + PW'(1);
		end else if (port_rd) begin
			d.ptr = q.ptr + PW'(1);
		end
	end

	assign rdata = q.mem[q.ptr];

	always_ff @(posedge core_clk) begin
		q <= d;
	end

endmodule
`default_nettype wire

//--- logic/adapter_host_decode.sv
`timescale 1ns/100ps
`default_nettype none
module adapter_host_decode #(
	parameter logic [2:0] REVISION_CODE = 3'h5,
	parameter int         PORT_DEPTH    = 16
) (
	input  wire logic                         core_clk,
	input  wire logic                         resetn,
	input  wire host_decode_pkg::io_req_type  io_req,
	input  wire host_decode_pkg::mem_req_type mem_req,
	input  wire logic [7:0]                   io_base_jumper,
	input  wire logic [3:0]                   memory_base_jumper,
	output var  logic [7:0]                   io_rdata,
	output var  logic                         io_rdata_valid,
	output var  logic [7:0]                   mem_rdata,
	output var  logic                         mem_rdata_valid,
	output var  host_decode_pkg::decode_type  decode,
	output var  host_decode_pkg::regs_type    regs,
	output var  logic                         soft_reset
);
	import host_decode_pkg::*;

	localparam int JW = 12;

	typedef struct packed {
		logic [SYNC_STAGES-1:0][JW-1:0] jumper_sync;
		regs_type                       regs;
		decode_type                     dec;
		logic [7:0]                     io_rdata;
		logic                           io_rvalid;
		logic [7:0]                     mem_rdata;
		logic                           mem_rvalid;
	} state_type;

	state_type  q;
	state_type  d;
	logic [7:0] port_rdata;
	logic       port_rd;
	logic       port_wr;
	logic       port_clear;

	function automatic logic [15:0] io_base_of(input logic [7:0] opt);
		logic [15:0] base;
		base = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (opt[i]) begin
				base = IO_BASE_TABLE[i];
			end
		end
		return base;
	endfunction

	function automatic logic [19:0] rom_base_of(input logic [3:0] opt);
		logic [19:0] base;
		base = 20'h0_0000;
		for (int i = 0; i < 4; i++) begin
			if (opt[i]) begin
				base = ROM_BASE_TABLE[i];
			end
		end
		return base;
	endfunction

	// Everything except the two jumper registers and the control register returns to its reset value; control takes ctrl.
	function automatic regs_type cleared(input regs_type r, input logic [7:0] ctrl);
		regs_type c;
		c = '{default: RESET_ZERO};
		c.io_base  = r.io_base;
		c.rom_base = r.rom_base;
		c.ctrl     = ctrl;
		return c;
	endfunction

	logic [15:0] io_base;
	logic [19:0] rom_base;
	logic        io_base_ok;
	logic        rom_base_ok;
	logic        ga_hit;
	logic        win_hit;
	logic        mem_hit;
	logic        srst_q;
	logic [15:0] ga_ofs;
	logic [19:0] vector;

	always_comb begin
		d = q;
		d.io_rvalid  = 1'b0;
		d.mem_rvalid = 1'b0;
		d.dec.lan_sel  = 1'b0;
		d.dec.prom_sel = 1'b0;
		d.dec.rom_sel  = 1'b0;
		d.dec.ram_sel  = 1'b0;
		port_rd    = 1'b0;
		port_wr    = 1'b0;
		port_clear = 1'b0;

		// The first stage feeds only the second; the jumper value is taken once
		// the second and third stages agree.
		d.jumper_sync[0] = {memory_base_jumper, io_base_jumper};
		for (int s = 1; s < SYNC_STAGES; s++) begin
			d.jumper_sync[s] = q.jumper_sync[s-1];
		end

		srst_q      = q.regs.ctrl[CTRL_SRST_BIT];
		io_base     = io_base_of(q.regs.io_base);
		io_base_ok  = |q.regs.io_base;
		rom_base    = rom_base_of(q.regs.rom_base[7:ROM_OPT_LO]);
		rom_base_ok = |q.regs.rom_base[7:ROM_OPT_LO];
		ga_ofs      = io_req.addr - io_base;
		// Full 16-bit compare so partial decoders elsewhere cannot alias us.
		ga_hit  = io_base_ok && (io_req.addr[15:4] == ga_ofs[15:4] + io_base[15:4])
			&& (ga_ofs[15:4] == OFS_PAGE_FIRST[15:4]);
		win_hit = io_base_ok && (io_req.addr[15:4] == io_base[15:4]);
		mem_hit = rom_base_ok
			&& (mem_req.addr[19:MEM_WIN_LO] == rom_base[19:MEM_WIN_LO]);
		vector  = {q.regs.vector_2[3:0], q.regs.vector_1, q.regs.vector_0};

		if (!resetn) begin
			// Power-on reset also reloads the jumper registers.
			d.regs = cleared(q.regs, RESET_CTRL);
			if (q.jumper_sync[1] == q.jumper_sync[2]) begin
				d.regs.io_base  = q.jumper_sync[2][7:0];
				d.regs.rom_base = {q.jumper_sync[2][11:8], 4'h0};
			end
			d.io_rdata  = RESET_ZERO;
			d.mem_rdata = RESET_ZERO;
			d.dec       = '0;
			port_clear  = 1'b1;
		end else begin
			// Register reads stay available during software reset.
			if (io_req.rd && ga_hit) begin
				d.io_rvalid = 1'b1;
				case (ga_ofs)
					OFS_PAGE_FIRST: d.io_rdata = q.regs.page_first;
					OFS_PAGE_LAST:  d.io_rdata = q.regs.page_last;
					OFS_BURST_LEN:  d.io_rdata = q.regs.burst_len;
					OFS_IO_BASE:    d.io_rdata = q.regs.io_base;
					OFS_ROM_BASE:   d.io_rdata = q.regs.rom_base;
					OFS_ARRAY_CFG:  d.io_rdata = q.regs.array_cfg;
					OFS_CTRL:       d.io_rdata = q.regs.ctrl;
					OFS_STATUS:     d.io_rdata = {5'h00, REVISION_CODE};
					OFS_IRQ_DMA:    d.io_rdata = q.regs.irq_dma;
					OFS_DMA_HIGH:   d.io_rdata = q.regs.dma_high;
					OFS_DMA_LOW:    d.io_rdata = q.regs.dma_low;
					OFS_VECTOR_2:   d.io_rdata = q.regs.vector_2;
					OFS_VECTOR_1:   d.io_rdata = q.regs.vector_1;
					OFS_VECTOR_0:   d.io_rdata = q.regs.vector_0;
					OFS_PORT_LOW, OFS_PORT_HIGH: begin
						d.io_rdata = port_rdata;
						port_rd    = !srst_q;
					end
					default:        d.io_rdata = RESET_ZERO;
				endcase
			end

			if (io_req.wr && ga_hit) begin
				if (ga_ofs == OFS_CTRL) begin
					if (srst_q) begin
						// Leaving reset ignores the other bits written with it.
						d.regs.ctrl = io_req.wdata[CTRL_SRST_BIT]
							? CTRL_IN_SRST : RESET_CTRL;
					end else if (io_req.wdata[CTRL_SRST_BIT]) begin
						d.regs.ctrl = CTRL_IN_SRST;
					end else begin
						d.regs.ctrl = io_req.wdata;
					end
				end else if (!srst_q) begin
					case (ga_ofs)
						OFS_PAGE_FIRST: d.regs.page_first = io_req.wdata;
						OFS_PAGE_LAST:  d.regs.page_last  = io_req.wdata;
						OFS_BURST_LEN:  d.regs.burst_len  = io_req.wdata;
						OFS_ARRAY_CFG:  d.regs.array_cfg  = io_req.wdata;
						OFS_IRQ_DMA:    d.regs.irq_dma    = io_req.wdata;
						OFS_DMA_HIGH:   d.regs.dma_high   = io_req.wdata;
						OFS_DMA_LOW:    d.regs.dma_low    = io_req.wdata;
						OFS_VECTOR_2:   d.regs.vector_2   = io_req.wdata;
						OFS_VECTOR_1:   d.regs.vector_1   = io_req.wdata;
						OFS_VECTOR_0:   d.regs.vector_0   = io_req.wdata;
						OFS_PORT_LOW, OFS_PORT_HIGH: port_wr = 1'b1;
						default: ; // Jumper and status registers ignore writes.
					endcase
				end
			end

			// While software reset holds, the base window and memory decode are
			// silent so that no access reaches the outside.
			if (!srst_q && win_hit && (io_req.rd || io_req.wr)) begin
				d.dec.lan_reg = io_req.addr[3:0];
				case (q.regs.ctrl[CTRL_WIN_HI_BIT:CTRL_WIN_LO_BIT])
					2'b00: d.dec.lan_sel = 1'b1;
					2'b01: begin
						d.dec.prom_sel  = 1'b1;
						d.dec.prom_byte = {1'b0, io_req.addr[3:0]};
					end
					2'b10: begin
						d.dec.prom_sel  = 1'b1;
						d.dec.prom_byte = {1'b1, io_req.addr[3:0]};
					end
					default: ;
				endcase
			end

			if (!srst_q && mem_hit) begin
				if (q.regs.array_cfg[CFG_RAM_MAP_BIT]) begin
					// Bank bits supply A15..A13; bank 1 gives 2000h-3FFFh.
					d.dec.ram_sel    = mem_req.rd || mem_req.wr;
					d.dec.local_addr = {q.regs.array_cfg[CFG_BANK_HI:0],
						mem_req.addr[MEM_WIN_LO-1:0]};
				end else if (mem_req.rd) begin
					if (&mem_req.addr[MEM_WIN_LO-1:ROM_TAIL_LO]) begin
						d.mem_rdata  = q.regs.io_base;
						d.mem_rvalid = 1'b1;
					end else begin
						d.dec.rom_sel    = 1'b1;
						d.dec.local_addr = {3'h0, mem_req.addr[MEM_WIN_LO-1:0]};
					end
				end
			end

			if (!srst_q && mem_req.rd && (mem_req.addr == vector)) begin
				d.regs.array_cfg[CFG_RAM_MAP_BIT] = 1'b0;
			end

			// A pending or held software reset overrides every other register
			// and data port update made in this cycle.
			if (d.regs.ctrl[CTRL_SRST_BIT]) begin
				d.regs     = cleared(q.regs, CTRL_IN_SRST);
				port_clear = 1'b1;
				port_wr    = 1'b0;
				port_rd    = 1'b0;
			end
		end
	end

	data_port_file #(
		.DEPTH(PORT_DEPTH)
	) u_port (
		.core_clk  (core_clk),
		.clear_ptr (port_clear),
		.port_rd   (port_rd),
		.port_wr   (port_wr),
		.wdata     (io_req.wdata),
		.rdata     (port_rdata)
	);

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign io_rdata        = q.io_rdata;
	assign io_rdata_valid  = q.io_rvalid;
	assign mem_rdata       = q.mem_rdata;
	assign mem_rdata_valid = q.mem_rvalid;
	assign decode          = q.dec;
	assign regs            = q.regs;
	assign soft_reset      = q.regs.ctrl[CTRL_SRST_BIT];

endmodule
`default_nettype wire

//--- test/adapter_host_decode_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adapter_host_decode_assertions (
	input wire logic                         core_clk,
	input wire logic                         resetn,
	input wire host_decode_pkg::io_req_type  io_req,
	input wire host_decode_pkg::mem_req_type mem_req,
	input wire logic [7:0]                   io_rdata,
	input wire logic                         io_rdata_valid,
	input wire logic [7:0]                   mem_rdata,
	input wire logic                         mem_rdata_valid,
	input wire host_decode_pkg::decode_type  decode,
	input wire host_decode_pkg::regs_type    regs,
	input wire logic                         soft_reset
);
	import host_decode_pkg::*;
	logic [15:0] base;
	logic        rom_hit;
	logic        ctrl_wr;
	// Base and window follow the captured jumpers, so any setting with a nonzero I/O jumper and at most one memory jumper bit is judged right.
	always_comb begin
		base = 16'h0000;
		rom_hit = 1'b0;
		for (int i = 0; i < 8; i++) if (regs.io_base[i]) base = IO_BASE_TABLE[i];
		for (int i = 0; i < 4; i++)
			if (regs.rom_base[4+i] && mem_req.addr[19:13] == ROM_BASE_TABLE[i][19:13]) rom_hit = 1'b1;
		ctrl_wr = io_req.wr && io_req.addr == base + OFS_CTRL;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	chk_ctrl_read: assert property (io_req.rd && !io_req.wr && !soft_reset && io_req.addr == base + OFS_CTRL
		|=> io_rdata_valid && io_rdata == $past(regs.ctrl)) else $error("Control read data wrong.");
	chk_srst_readback: assert property (io_req.rd && soft_reset && io_req.addr == base + OFS_CTRL
		|=> io_rdata_valid && io_rdata == 8'h0b) else $error("Control read in reset wrong.");
	chk_srst_enter: assert property (ctrl_wr && io_req.wdata[0] |=> soft_reset && regs.array_cfg == 8'h00
		&& regs.page_first == 8'h00 && regs.vector_0 == 8'h00) else $error("Reset entry wrong.");
	chk_srst_hold: assert property (soft_reset && !ctrl_wr |=> soft_reset) else $error("Reset ended early.");
	chk_srst_exit: assert property (soft_reset && ctrl_wr && !io_req.wdata[0]
		|=> !soft_reset && regs.ctrl == 8'h0a) else $error("Reset exit wrong.");
	chk_window_route: assert property (io_req.rd && io_req.addr[15:4] == base[15:4] && !soft_reset
		|=> decode.lan_sel == ($past(regs.ctrl[3:2]) == 2'b00)
		&& decode.prom_sel == ($past(regs.ctrl[3]) ^ $past(regs.ctrl[2]))) else $error("Window route wrong.");
	chk_prom_tail: assert property (mem_req.rd && rom_hit && !regs.array_cfg[3] && !soft_reset
		&& (&mem_req.addr[12:1]) |=> mem_rdata_valid && mem_rdata == regs.io_base) else $error("Tail read wrong.");
	chk_ram_map: assert property (mem_req.rd && rom_hit && regs.array_cfg[3] && !soft_reset
		|=> decode.ram_sel && decode.local_addr[12:0] == $past(mem_req.addr[12:0])) else $error("RAM map wrong.");
	chk_vector_clear: assert property (mem_req.rd && !soft_reset
		&& mem_req.addr == {regs.vector_2[3:0], regs.vector_1, regs.vector_0}
		|=> !regs.array_cfg[3]) else $error("Vector match kept mapping.");
	chk_jumper_hold: assert property (1'b1 |=> $stable(regs.io_base) && $stable(regs.rom_base))
		else $error("Jumper register changed.");
endmodule
bind adapter_host_decode adapter_host_decode_assertions chk (.core_clk(core_clk), .resetn(resetn),
	.io_req(io_req), .mem_req(mem_req), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
	.mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid), .decode(decode), .regs(regs),
	.soft_reset(soft_reset));
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic                         core_clk,
	output var  host_decode_pkg::io_req_type  io_req,
	output var  host_decode_pkg::mem_req_type mem_req
);
	import host_decode_pkg::*;
	initial begin
		io_req = '{16'h0000, 1'b0, 1'b0, 8'h00};
		mem_req = '{20'h0_0000, 1'b0, 1'b0};
	end
	// A released bus shows the inverse of its last address and data with both strobes low, so stale data never passes.
	task automatic io_cycle(input logic [15:0] a, input logic rd, input logic [7:0] d);
		@(posedge core_clk);
		#1 io_req = '{a, rd, !rd, d};
		@(posedge core_clk);
		#1 io_req = '{~a, 1'b0, 1'b0, ~d};
	endtask
	task automatic mem_read(input logic [19:0] a);
		@(posedge core_clk);
		#1 mem_req = '{a, 1'b1, 1'b0};
		@(posedge core_clk);
		#1 mem_req = '{~a, 1'b0, 1'b0};
	endtask
endmodule
`default_nettype wire

//--- test/adapter_host_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adapter_host_decode_tb;
	import host_decode_pkg::*;
	localparam logic [2:0]  REV = 3'h5;
	localparam logic [15:0] GA  = IO_BASE_TABLE[7] + OFS_PAGE_FIRST;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  io_base_jumper = 8'h80;
	logic [3:0]  memory_base_jumper = 4'b0001;
	io_req_type  io_req;
	mem_req_type mem_req;
	logic [7:0]  io_rdata, mem_rdata;
	logic        io_rdata_valid, mem_rdata_valid, soft_reset;
	decode_type  decode;
	regs_type    regs;
	int          fail_count = 0;
	int          check_count = 0;
	logic [7:0]  mdl [16];
	logic        srst = 1'b0;
	logic [7:0]  rnd = 8'h55;
	always #20 core_clk = ~core_clk;
	host_model h (.core_clk(core_clk), .io_req(io_req), .mem_req(mem_req));
	adapter_host_decode #(.REVISION_CODE(REV), .PORT_DEPTH(16)) dut (.core_clk(core_clk),
		.resetn(resetn), .io_req(io_req), .mem_req(mem_req), .io_base_jumper(io_base_jumper),
		.memory_base_jumper(memory_base_jumper), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
		.mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid), .decode(decode), .regs(regs),
		.soft_reset(soft_reset));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input int a, input logic [7:0] d);
		h.io_cycle(GA + 16'(a), 1'b0, d);
		if (a == 6 && d[0]) begin
			srst = 1'b1;
			foreach (mdl[i]) if (!(i inside {3, 4, 7})) mdl[i] = 8'h00;
			mdl[6] = 8'h0b;
		end else if (a == 6) begin
			mdl[6] = srst ? 8'h0a : d;
			srst = 1'b0;
		end else if (!srst && !(a inside {3, 4, 7})) mdl[a] = d;
		chk({7'h00, soft_reset}, {7'h00, srst});
	endtask
	task automatic rd(input int a);
		h.io_cycle(GA + 16'(a), 1'b1, 8'h00);
		chk({7'h00, io_rdata_valid}, 8'h01);
		chk(io_rdata, mdl[a]);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 resetn = 1'b1;
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[3] = io_base_jumper;
		mdl[4] = {memory_base_jumper, 4'h0};
		mdl[6] = RESET_CTRL;
		mdl[7] = {5'h00, REV};
		for (int a = 0; a < 14; a++) rd(a);
		for (int a = 0; a < 14; a++) begin
			rnd = lfsr(rnd);
			// The burst timer only ever gets 0 or 8, a multiple of four below 12.
			if (a != 6) wr(a, (a == 2) ? (rnd & 8'h08) : rnd);
		end
		wr(0, 8'h26);
		wr(1, 8'h40);
		wr(2, 8'h08);
		for (int a = 0; a < 14; a++) rd(a);
		h.io_cycle(16'h0710, 1'b1, 8'h00);
		chk({7'h00, io_rdata_valid}, 8'h00);
		h.io_cycle(16'hf706, 1'b1, 8'h00);
		chk({7'h00, io_rdata_valid}, 8'h00);
		wr(14, 8'ha5);
		wr(15, 8'h3c);
		wr(6, 8'h03);
		for (int a = 0; a < 14; a++) rd(a);
		wr(0, 8'h77);
		rd(0);
		h.io_cycle(IO_BASE_TABLE[7] + 16'h0005, 1'b1, 8'h00);
		chk({7'h00, decode.prom_sel}, 8'h00);
		wr(6, 8'h0e);
		rd(6);
		h.io_cycle(GA + OFS_PORT_LOW - OFS_PAGE_FIRST, 1'b1, 8'h00);
		chk(io_rdata, 8'ha5);
		h.io_cycle(GA + OFS_PORT_HIGH - OFS_PAGE_FIRST, 1'b1, 8'h00);
		chk(io_rdata, 8'h3c);
		for (int k = 0; k < 4; k++) begin
			wr(6, 8'(k << 2));
			h.io_cycle(IO_BASE_TABLE[7] + 16'h0005, 1'b1, 8'h00);
			chk({7'h00, decode.lan_sel}, 8'(k == 0));
			chk({4'h0, decode.lan_reg}, 8'h05);
			chk({7'h00, decode.prom_sel}, 8'(k == 1 || k == 2));
			if (k == 1 || k == 2) chk({3'h0, decode.prom_byte}, {3'h0, k[1], 4'h5});
		end
		h.mem_read(20'hc_9ffe);
		chk({7'h00, mem_rdata_valid}, 8'h01);
		chk(mem_rdata, io_base_jumper);
		h.mem_read(20'hc_8010);
		chk({7'h00, decode.rom_sel}, 8'h01);
		wr(5, 8'h49);
		h.mem_read(20'hc_8010);
		chk({7'h00, decode.ram_sel}, 8'h01);
		chk(decode.local_addr[15:8], 8'h20);
		chk(decode.local_addr[7:0], 8'h10);
		wr(11, 8'h00);
		wr(12, 8'h00);
		wr(13, 8'h24);
		h.mem_read(20'h0_0024);
		mdl[5][3] = 1'b0;
		rd(5);
		// A second power-on reset with other jumpers moves both the I/O and memory ranges.
		@(posedge core_clk);
		#1 resetn = 1'b0;
		io_base_jumper = 8'h01;
		memory_base_jumper = 4'b1000;
		repeat (20) @(posedge core_clk);
		#1 resetn = 1'b1;
		h.io_cycle(GA + OFS_CTRL - OFS_PAGE_FIRST, 1'b1, 8'h00);
		chk({7'h00, io_rdata_valid}, 8'h00);
		h.io_cycle(IO_BASE_TABLE[0] + OFS_IO_BASE, 1'b1, 8'h00);
		chk({7'h00, io_rdata_valid}, 8'h01);
		chk(io_rdata, io_base_jumper);
		h.io_cycle(IO_BASE_TABLE[0] + OFS_ROM_BASE, 1'b1, 8'h00);
		chk(io_rdata, {memory_base_jumper, 4'h0});
		h.io_cycle(IO_BASE_TABLE[0] + OFS_ARRAY_CFG, 1'b1, 8'h00);
		chk(io_rdata, RESET_ZERO);
		h.io_cycle(IO_BASE_TABLE[0] + OFS_CTRL, 1'b1, 8'h00);
		chk(io_rdata, RESET_CTRL);
		h.mem_read(20'hd_dffe);
		chk({7'h00, mem_rdata_valid}, 8'h01);
		chk(mem_rdata, io_base_jumper);
		final_report;
	end
	// The run needs a few hundred cycles; the limit leaves ample margin.
	initial begin
		#400000;
		fail_count++;
		final_report;
	end
endmodule
`default_nettype wire
